// ==== core/alc_consts.svh ====
/*
 Register offsets, field positions, reset values and timing counts
 of the asynchronous link transfer and acknowledge block.
 Assumes inclusion by its bare name from the core.
*/
`ifndef ALC_CONSTS_SVH
`define ALC_CONSTS_SVH

// Byte offsets on the 9-bit host address
`define ALC_OFF_LINK_CONTROL    9'h004
`define ALC_OFF_ASYNC_QUEUE_EN  9'h084
`define ALC_OFF_ASYNC_INT_ACK   9'h0A0
`define ALC_OFF_REQ_XFER        9'h0C0
`define ALC_OFF_RSP_XFER        9'h0C4
`define ALC_OFF_CONFIRM         9'h0C8

// link_control fields
`define ALC_LC_ISO_TALK_BIT     0
`define ALC_LC_BUSY_LSB         27
`define ALC_LC_BUSY_MSB         29
`define ALC_BUSY_SINGLE_PHASE   3'h3
`define ALC_LC_RESET            32'h0000_0000

// async_queue_enable fields
`define ALC_QE_REQ_EN_BIT       0
`define ALC_QE_REQ_IDLE_BIT     2
`define ALC_QE_REQ_FULL_BIT     3
`define ALC_QE_RSP_EN_BIT       4
`define ALC_QE_RSP_IDLE_BIT     6
`define ALC_QE_RSP_FULL_BIT     7
`define ALC_QE_RESET            8'h11

// async_interrupt_ack fields
`define ALC_IA_RX_AVAIL_BIT     0
`define ALC_IA_REQ_WR_BIT       1
`define ALC_IA_RSP_WR_BIT       2

// Acknowledge codes and confirmation layout
`define ALC_ACK_COMPLETE        4'h1
`define ALC_ACK_BUSY_X          4'h4
`define ALC_ACK_BUSY_A          4'h5
`define ALC_ACK_BUSY_B          4'h6
`define ALC_ACK_DATA_ERROR      4'hD
`define ALC_ACK_MISSING         4'h0
`define ALC_CONF_MISSING_BIT    4

// PHY control encodings
`define ALC_CTL_IDLE            2'h0
`define ALC_CTL_RECEIVE         2'h2
`define ALC_CTL_TRANSMIT        2'h2
`define ALC_CTL_GRANT           2'h3

// Link-clock cycle counts and the fairness interval count
`define ALC_ACK_WAIT_CYC        8'h40
`define ALC_ISO_GRANT_CYC       8'h20
`define ALC_FAIR_INTERVALS      3'h4

`endif

// ==== core/alc_pkg.sv ====
/*
 Types shared by the transfer and acknowledge core, its checker and the testbench.
 Assumes alc_consts.svh is on the include path.
*/
package alc_pkg;

    // Host pin bundle, sampled as one group
    typedef struct packed {
        logic       cs_n;
        logic       wr_n;
        logic       rd_n;
        logic [8:0] addr;
        logic [7:0] data;
    } alc_hif_t;

    // Decoded receive summary from the link receiver
    typedef struct packed {
        logic        for_us;
        logic        need_busy;
        logic [15:0] hdr_len;
        logic [15:0] act_len;
    } alc_rx_t;

    // Link-side bus events, one-cycle pulses
    typedef struct packed {
        logic bus_reset;
        logic cycle_start;
        logic fair_gap;
    } alc_ev_t;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_TX,
        LS_WAIT_ACK,
        LS_ACK_OUT,
        LS_ISO_REQ
    } alc_link_st_t;

endpackage : alc_pkg

// ==== core/alc_fifo.sv ====
/*
 Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
 Assumes one common asynchronous active-low reset for both clocks.
*/
`timescale 1ns/1ps
module alc_fifo #(
    parameter int W  = 32,
    parameter int D  = 8,
    parameter int AW = 3
) (
    input  wire logic         wr_clk,
    input  wire logic         rd_clk,
    input  wire logic         arst_n,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    logic [W-1:0] mem [D];
    logic [AW:0]  wbin_r, wbin_nxt, wgray_r, rbin_r, rbin_nxt, rgray_r;
    logic [AW:0]  rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : g2b

    // Full and empty come from the far pointer after two flops
    assign wr_ready = (wbin_r - g2b(rg_s2_r)) != (AW+1)'(D);
    assign rd_valid = rgray_r != wg_s2_r;
    assign rd_data  = mem[rbin_r[AW-1:0]];

    always_comb begin
        wbin_nxt = wbin_r + (AW+1)'(wr_valid && wr_ready);
        rbin_nxt = rbin_r + (AW+1)'(rd_valid && rd_ready);
    end

    // Storage has no reset; only written slots are ever read
    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge wr_clk or negedge arst_n) begin
        if (!arst_n) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    always_ff @(posedge rd_clk or negedge arst_n) begin
        if (!arst_n) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
        end
    end

endmodule : alc_fifo

// ==== core/alc_core.sv ====
/*
 Transfer registers, queue status and link-side acknowledge logic.
 Host byte port on ref_clk, PHY side on the link clock from the PHY.
 Assumes host pins held stable for several ref_clk cycles per access.
*/
`timescale 1ns/1ps
`include "alc_consts.svh"

// Notes on behaviour
// - A quadlet written while its FIFO is full stays held in the transfer register.
// - The idle indication stays cleared while a quadlet waits there for FIFO space.
// - Queue enable register shows request FIFO full at bit 3 and response full at bit 7.
// - Interrupt acknowledge register bits 1 and 2 flag request and response moves into FIFO.
// - After four fairness intervals with nothing busied, all retry phase subactions count as sent.
// - Busy control is link_control bits 29 to 27, and 011 selects single-phase retry inbound.
// - A sent block request with zero payload still awaits the ack and confirms with it.
// - A received block packet for this node with a length mismatch gets ack_data_error.
// - As root and talker, isochronous sending resumes after every bus reset.
// - PHY pins drive low during reset and turn to inputs right after release.
// - Writing byte 3 of a transfer register clears its idle flag and the move into the FIFO sets it.
// - A request without an ack yields a synthesized confirmation and raises quadlet available.
module alc_core #(
    parameter int FIFO_W = 32,
    parameter int FIFO_D = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic              link_clk,
    input  wire alc_pkg::alc_hif_t hif_in,
    output logic [7:0]             hif_d_out,
    output logic                   hif_d_oe,
    input  wire logic [1:0]        phy_ctl_in,
    input  wire logic [7:0]        phy_d_in,
    output logic [1:0]             phy_ctl_out,
    output logic [7:0]             phy_d_out,
    output logic                   phy_ctl_oe,
    output logic                   phy_d_oe,
    output logic                   phy_lreq,
    input  wire logic              node_is_root,
    input  wire alc_pkg::alc_rx_t  rx_info,
    input  wire logic              rx_done,
    input  wire alc_pkg::alc_ev_t  bus_ev
);
    localparam int AW = $clog2(FIFO_D);

    function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
        return a[8:2] == off[8:2];
    endfunction : hit

    function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] l);
        return w[8*l +: 8];
    endfunction : lane_of

    // Host pin synchroniser; stage one feeds stage two only
    alc_pkg::alc_hif_t hs1_r, hs2_r;
    logic              wr_d_r;
    logic              tg_s1_r, tg_s2_r, tg_d_r, conf_tgl_r;
    logic [31:0]       conf_word_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hs1_r   <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, data: '0};
            hs2_r   <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, addr: '0, data: '0};
            wr_d_r  <= 1'b0;
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_d_r  <= 1'b0;
        end else begin
            hs1_r   <= hif_in;
            hs2_r   <= hs1_r;
            wr_d_r  <= !hs2_r.cs_n && !hs2_r.wr_n;
            tg_s1_r <= conf_tgl_r;
            tg_s2_r <= tg_s1_r;
            tg_d_r  <= tg_s2_r;
        end
    end

    logic wr_act, wr_edge, rd_act, conf_ev;
    assign wr_act  = !hs2_r.cs_n && !hs2_r.wr_n;
    assign wr_edge = wr_act && !wr_d_r;
    assign rd_act  = !hs2_r.cs_n && !hs2_r.rd_n && hs2_r.wr_n; // Write wins when both low
    assign conf_ev = tg_s2_r != tg_d_r;

    // Host register state
    logic [31:0] lc_r, lc_nxt, req_sh_r, req_sh_nxt, rsp_sh_r, rsp_sh_nxt;
    logic [31:0] conf_r, conf_nxt;
    logic [7:0]  qe_r, qe_nxt, hd_r, hd_nxt;
    logic        req_pend_r, req_pend_nxt, rsp_pend_r, rsp_pend_nxt;
    logic        req_mv_r, req_mv_nxt, rsp_mv_r, rsp_mv_nxt, avail_r, avail_nxt;
    logic        hoe_r;
    logic        req_wr_ready, rsp_wr_ready, req_push, rsp_push;
    logic [31:0] qe_word, ia_word, rd_word;

    assign req_push = req_pend_r && qe_r[`ALC_QE_REQ_EN_BIT] && req_wr_ready;
    assign rsp_push = rsp_pend_r && qe_r[`ALC_QE_RSP_EN_BIT] && rsp_wr_ready;

    // Status words; idle is simply the absence of a held quadlet
    always_comb begin
        qe_word = {24'h00_0000, qe_r};
        qe_word[`ALC_QE_REQ_IDLE_BIT] = !req_pend_r;
        qe_word[`ALC_QE_RSP_IDLE_BIT] = !rsp_pend_r;
        qe_word[`ALC_QE_REQ_FULL_BIT] = !req_wr_ready;
        qe_word[`ALC_QE_RSP_FULL_BIT] = !rsp_wr_ready;
        ia_word = 32'h0000_0000;
        ia_word[`ALC_IA_RX_AVAIL_BIT] = avail_r;
        ia_word[`ALC_IA_REQ_WR_BIT] = req_mv_r;
        ia_word[`ALC_IA_RSP_WR_BIT] = rsp_mv_r;
        if (hit(hs2_r.addr, `ALC_OFF_LINK_CONTROL)) begin
            rd_word = lc_r;
        end else if (hit(hs2_r.addr, `ALC_OFF_ASYNC_QUEUE_EN)) begin
            rd_word = qe_word;
        end else if (hit(hs2_r.addr, `ALC_OFF_ASYNC_INT_ACK)) begin
            rd_word = ia_word;
        end else if (hit(hs2_r.addr, `ALC_OFF_CONFIRM)) begin
            rd_word = conf_r;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    // Host writes, then hardware events; sets come last so they win
    always_comb begin
        lc_nxt       = lc_r;
        qe_nxt       = qe_r;
        req_sh_nxt   = req_sh_r;
        rsp_sh_nxt   = rsp_sh_r;
        req_pend_nxt = req_pend_r;
        rsp_pend_nxt = rsp_pend_r;
        req_mv_nxt   = req_mv_r;
        rsp_mv_nxt   = rsp_mv_r;
        avail_nxt    = avail_r;
        conf_nxt     = conf_r;
        hd_nxt       = lane_of(rd_word, hs2_r.addr[1:0]);
        if (wr_edge) begin
            if (hit(hs2_r.addr, `ALC_OFF_LINK_CONTROL)) begin
                lc_nxt[8*hs2_r.addr[1:0] +: 8] = hs2_r.data;
            end else if (hit(hs2_r.addr, `ALC_OFF_ASYNC_QUEUE_EN)) begin
                if (hs2_r.addr[1:0] == 2'h0) begin
                    qe_nxt[`ALC_QE_REQ_EN_BIT] = hs2_r.data[`ALC_QE_REQ_EN_BIT];
                    qe_nxt[`ALC_QE_RSP_EN_BIT] = hs2_r.data[`ALC_QE_RSP_EN_BIT];
                end
            end else if (hit(hs2_r.addr, `ALC_OFF_ASYNC_INT_ACK)) begin
                if (hs2_r.addr[1:0] == 2'h0) begin
                    avail_nxt  = avail_r && !hs2_r.data[`ALC_IA_RX_AVAIL_BIT];
                    req_mv_nxt = req_mv_r && !hs2_r.data[`ALC_IA_REQ_WR_BIT];
                    rsp_mv_nxt = rsp_mv_r && !hs2_r.data[`ALC_IA_RSP_WR_BIT];
                end
            end else if (hit(hs2_r.addr, `ALC_OFF_REQ_XFER) && !req_pend_r) begin
                req_sh_nxt[8*hs2_r.addr[1:0] +: 8] = hs2_r.data;
                req_pend_nxt = hs2_r.addr[1:0] == 2'h3;
            end else if (hit(hs2_r.addr, `ALC_OFF_RSP_XFER) && !rsp_pend_r) begin
                rsp_sh_nxt[8*hs2_r.addr[1:0] +: 8] = hs2_r.data;
                rsp_pend_nxt = hs2_r.addr[1:0] == 2'h3;
            end
        end
        // Move into FIFO sets idle and the moved flag
        if (req_push) begin
            req_pend_nxt = 1'b0;
            req_mv_nxt   = 1'b1;
        end
        if (rsp_push) begin
            rsp_pend_nxt = 1'b0;
            rsp_mv_nxt   = 1'b1;
        end
        if (conf_ev) begin
            conf_nxt  = conf_word_r; // Held stable across the toggle
            avail_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lc_r       <= `ALC_LC_RESET;
            qe_r       <= `ALC_QE_RESET;
            req_sh_r   <= 32'h0000_0000;
            rsp_sh_r   <= 32'h0000_0000;
            req_pend_r <= 1'b0;
            rsp_pend_r <= 1'b0;
            req_mv_r   <= 1'b0;
            rsp_mv_r   <= 1'b0;
            avail_r    <= 1'b0;
            conf_r     <= 32'h0000_0000;
            hd_r       <= 8'h00;
            hoe_r      <= 1'b0;
        end else begin
            lc_r       <= lc_nxt;
            qe_r       <= qe_nxt;
            req_sh_r   <= req_sh_nxt;
            rsp_sh_r   <= rsp_sh_nxt;
            req_pend_r <= req_pend_nxt;
            rsp_pend_r <= rsp_pend_nxt;
            req_mv_r   <= req_mv_nxt;
            rsp_mv_r   <= rsp_mv_nxt;
            avail_r    <= avail_nxt;
            conf_r     <= conf_nxt;
            hd_r       <= hd_nxt;
            hoe_r      <= rd_act;
        end
    end

    assign hif_d_out = hd_r;
    assign hif_d_oe  = hoe_r;
    // Queues into the link domain
    logic        req_rd_valid, req_rd_ready, rsp_rd_valid, rsp_rd_ready;
    logic [31:0] req_rd_data, rsp_rd_data;
    alc_fifo #(.W(FIFO_W), .D(FIFO_D), .AW(AW)) u_req_fifo (
        .wr_clk   (ref_clk),
        .rd_clk   (link_clk),
        .arst_n   (arst_n),
        .wr_valid (req_push),
        .wr_ready (req_wr_ready),
        .wr_data  (req_sh_r),
        .rd_valid (req_rd_valid),
        .rd_ready (req_rd_ready),
        .rd_data  (req_rd_data)
    );
    alc_fifo #(.W(FIFO_W), .D(FIFO_D), .AW(AW)) u_rsp_fifo (
        .wr_clk   (ref_clk),
        .rd_clk   (link_clk),
        .arst_n   (arst_n),
        .wr_valid (rsp_push),
        .wr_ready (rsp_wr_ready),
        .wr_data  (rsp_sh_r),
        .rd_valid (rsp_rd_valid),
        .rd_ready (rsp_rd_ready),
        .rd_data  (rsp_rd_data)
    );

    // Quasi-static control bits into the link domain
    logic [3:0] lk_s1_r, lk_s2_r;
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_s1_r <= 4'h0;
            lk_s2_r <= 4'h0;
        end else begin
            lk_s1_r <= {lc_r[`ALC_LC_BUSY_MSB:`ALC_LC_BUSY_LSB], lc_r[`ALC_LC_ISO_TALK_BIT]};
            lk_s2_r <= lk_s1_r;
        end
    end

    logic single_phase, iso_talker;
    assign single_phase = lk_s2_r[3:1] == `ALC_BUSY_SINGLE_PHASE;
    assign iso_talker   = lk_s2_r[0];

    // Link-side state
    alc_pkg::alc_link_st_t st_r, st_nxt;
    logic [31:0] sh_r, sh_nxt, conf_word_nxt;
    logic [7:0]  cnt_r, cnt_nxt, dout_nxt;
    logic [3:0]  ack_r, ack_nxt;
    logic [2:0]  fair_r, fair_nxt;
    logic [1:0]  ctl_nxt;
    logic        is_req_r, is_req_nxt, ack_pend_r, ack_pend_nxt, iso_pend_r, iso_pend_nxt;
    logic        phase_r, phase_nxt, busied_r, busied_nxt, conf_tgl_nxt;
    logic        oe_r, oe_nxt, lreq_r, lreq_nxt;
    logic [1:0]  ctl_r;
    logic [7:0]  dout_r;

    assign rsp_rd_ready = st_r == alc_pkg::LS_IDLE && !ack_pend_r && !iso_pend_r;
    assign req_rd_ready = rsp_rd_ready && !rsp_rd_valid;

    always_comb begin
        st_nxt        = st_r;
        sh_nxt        = sh_r;
        cnt_nxt       = cnt_r;
        ack_nxt       = ack_r;
        is_req_nxt    = is_req_r;
        ack_pend_nxt  = ack_pend_r;
        iso_pend_nxt  = iso_pend_r;
        phase_nxt     = phase_r;
        busied_nxt    = busied_r;
        fair_nxt      = fair_r;
        conf_word_nxt = conf_word_r;
        conf_tgl_nxt  = conf_tgl_r;
        oe_nxt        = 1'b0;
        ctl_nxt       = `ALC_CTL_IDLE;
        dout_nxt      = 8'h00;
        lreq_nxt      = 1'b0;
        // Inbound ack choice; a busied packet opens a retry phase
        if (rx_done && rx_info.for_us) begin
            ack_pend_nxt = 1'b1;
            if (rx_info.hdr_len != rx_info.act_len) begin
                ack_nxt = `ALC_ACK_DATA_ERROR;
            end else if (rx_info.need_busy) begin
                busied_nxt = 1'b1;
                ack_nxt = single_phase ? `ALC_ACK_BUSY_X :
                          (phase_r ? `ALC_ACK_BUSY_B : `ALC_ACK_BUSY_A);
            end else begin
                ack_nxt = `ALC_ACK_COMPLETE;
            end
        end
        // Phase ends only after four quiet fairness intervals
        if (bus_ev.fair_gap) begin
            busied_nxt = 1'b0;
            if (busied_r) begin
                fair_nxt = 3'h0;
            end else if (fair_r == `ALC_FAIR_INTERVALS - 3'h1) begin
                fair_nxt  = 3'h0;
                phase_nxt = !phase_r;
            end else begin
                fair_nxt = fair_r + 3'h1;
            end
        end
        // Request pended at the cycle start, then driven on phy_lreq from idle
        if (bus_ev.cycle_start && node_is_root && iso_talker) begin
            iso_pend_nxt = 1'b1;
        end
        case (st_r)
            alc_pkg::LS_IDLE: begin
                if (ack_pend_r) begin
                    ack_pend_nxt = 1'b0;
                    st_nxt = alc_pkg::LS_ACK_OUT;
                end else if (iso_pend_r) begin
                    iso_pend_nxt = 1'b0;
                    lreq_nxt = 1'b1;
                    cnt_nxt = `ALC_ISO_GRANT_CYC;
                    st_nxt = alc_pkg::LS_ISO_REQ;
                end else if (rsp_rd_valid || req_rd_valid) begin
                    sh_nxt = rsp_rd_valid ? rsp_rd_data : req_rd_data;
                    is_req_nxt = !rsp_rd_valid;
                    cnt_nxt = 8'h03;
                    st_nxt = alc_pkg::LS_TX;
                end
            end
            alc_pkg::LS_TX: begin
                oe_nxt = 1'b1;
                ctl_nxt = `ALC_CTL_TRANSMIT;
                dout_nxt = sh_r[31:24];
                sh_nxt = {sh_r[23:0], 8'h00};
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h00) begin
                    cnt_nxt = `ALC_ACK_WAIT_CYC;
                    st_nxt = is_req_r ? alc_pkg::LS_WAIT_ACK : alc_pkg::LS_IDLE;
                end
            end
            alc_pkg::LS_WAIT_ACK: begin
                // Same wait whatever the payload length
                cnt_nxt = cnt_r - 8'h01;
                if (phy_ctl_in == `ALC_CTL_RECEIVE) begin
                    conf_word_nxt = {28'h000_0000, phy_d_in[3:0]};
                    conf_tgl_nxt = !conf_tgl_r;
                    st_nxt = alc_pkg::LS_IDLE;
                end else if (cnt_r == 8'h00) begin
                    conf_word_nxt = 32'h0000_0000;
                    conf_word_nxt[`ALC_CONF_MISSING_BIT] = 1'b1;
                    conf_tgl_nxt = !conf_tgl_r;
                    st_nxt = alc_pkg::LS_IDLE;
                end
            end
            alc_pkg::LS_ACK_OUT: begin
                oe_nxt = 1'b1;
                ctl_nxt = `ALC_CTL_TRANSMIT;
                dout_nxt = {4'h0, ack_r};
                st_nxt = alc_pkg::LS_IDLE;
            end
            alc_pkg::LS_ISO_REQ: begin
                // Bounded wait; a lost grant retries next cycle
                cnt_nxt = cnt_r - 8'h01;
                lreq_nxt = 1'b1;
                if (phy_ctl_in == `ALC_CTL_GRANT || cnt_r == 8'h00) begin
                    lreq_nxt = 1'b0;
                    st_nxt = alc_pkg::LS_IDLE;
                end
            end
            default: st_nxt = alc_pkg::LS_IDLE;
        endcase
        // Bus reset abandons work but keeps talking enabled
        if (bus_ev.bus_reset) begin
            st_nxt = alc_pkg::LS_IDLE;
            iso_pend_nxt = 1'b0;
            ack_pend_nxt = 1'b0;
            oe_nxt = 1'b0;
            lreq_nxt = 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r        <= alc_pkg::LS_IDLE;
            sh_r        <= 32'h0000_0000;
            cnt_r       <= 8'h00;
            ack_r       <= 4'h0;
            is_req_r    <= 1'b0;
            ack_pend_r  <= 1'b0;
            iso_pend_r  <= 1'b0;
            phase_r     <= 1'b0;
            busied_r    <= 1'b0;
            fair_r      <= 3'h0;
            conf_word_r <= 32'h0000_0000;
            conf_tgl_r  <= 1'b0;
            oe_r        <= 1'b1;
            ctl_r       <= 2'h0;
            dout_r      <= 8'h00;
            lreq_r      <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            sh_r        <= sh_nxt;
            cnt_r       <= cnt_nxt;
            ack_r       <= ack_nxt;
            is_req_r    <= is_req_nxt;
            ack_pend_r  <= ack_pend_nxt;
            iso_pend_r  <= iso_pend_nxt;
            phase_r     <= phase_nxt;
            busied_r    <= busied_nxt;
            fair_r      <= fair_nxt;
            conf_word_r <= conf_word_nxt;
            conf_tgl_r  <= conf_tgl_nxt;
            oe_r        <= oe_nxt;
            ctl_r       <= ctl_nxt;
            dout_r      <= dout_nxt;
            lreq_r      <= lreq_nxt;
        end
    end

    assign phy_ctl_out = ctl_r;
    assign phy_d_out   = dout_r;
    assign phy_ctl_oe  = oe_r;
    assign phy_d_oe    = oe_r;
    assign phy_lreq    = lreq_r;

endmodule : alc_core

// ==== testbench/alc_checker.sv ====
/*
 Port-level assertions for the transfer and acknowledge core.
 Assumes binding onto alc_core; ports are watched by name.
*/
`timescale 1ns/1ps
module alc_checker (
    input wire logic             ref_clk,
    input wire logic             arst_n,
    input wire logic             link_clk,
    input wire alc_pkg::alc_hif_t hif_in,
    input wire logic             hif_d_oe,
    input wire logic [7:0]       phy_d_out,
    input wire logic             phy_ctl_oe,
    input wire logic             phy_d_oe,
    input wire logic             phy_lreq,
    input wire alc_pkg::alc_rx_t rx_info,
    input wire logic             rx_done
);
    // Link side: pin release, acks, request length
    a_pins_release: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(arst_n) |-> phy_ctl_oe ##1 !phy_ctl_oe && !phy_d_oe) else $error("pins held");
    a_len_error: assert property (@(posedge link_clk) disable iff (!arst_n)
        rx_done && rx_info.for_us && rx_info.hdr_len != rx_info.act_len
        |-> ##[1:12] phy_ctl_oe && phy_d_out == 8'h0d) else $error("no data error ack");
    a_busy_code: assert property (@(posedge link_clk) disable iff (!arst_n)
        rx_done && rx_info.for_us && rx_info.need_busy && rx_info.hdr_len == rx_info.act_len
        |-> ##[1:12] phy_ctl_oe && phy_d_out inside {8'h04, 8'h05, 8'h06}) else $error("busy");
    a_lreq_bound: assert property (@(posedge link_clk) disable iff (!arst_n)
        $rose(phy_lreq) |-> ##[1:40] !phy_lreq) else $error("request never ends");
    // Host side: read drive follows the strobes
    a_oe_reset: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(arst_n) |-> !hif_d_oe) else $error("host drive after reset");
    a_oe_cause: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(hif_d_oe) |-> !$past(hif_in.rd_n, 2) && !$past(hif_in.cs_n, 2)) else $error("oe");
    a_oe_rise: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(hif_in.rd_n) && !hif_in.cs_n && hif_in.wr_n |-> ##[2:4] hif_d_oe) else $error("rd");
    a_oe_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(hif_in.rd_n) |-> ##[2:4] !hif_d_oe) else $error("oe stuck");
endmodule : alc_checker
bind alc_core alc_checker chk (.*);

// ==== testbench/alc_phy_model.sv ====
/*
 PHY stand-in: free-running link clock, grants and acknowledges.
 Assumes the core's PHY pins; idle inputs sit low as with bus hold.
*/
`timescale 1ns/1ps
module alc_phy_model (
    output logic       link_clk,
    input  wire logic  phy_ctl_oe,
    input  wire logic  phy_lreq,
    input  wire logic  ack_on,
    output logic [1:0] phy_ctl_in,
    output logic [7:0] phy_d_in
);
    // Clock runs free; pins start low like bus hold
    initial begin
        phy_ctl_in = 2'h0;
        phy_d_in = 8'h00;
        link_clk = 1'b0;
        forever #24 link_clk = ~link_clk;
    end
    // Grant at once; ack complete one cycle after a send ends
    always @(posedge link_clk) begin
        phy_ctl_in <= phy_lreq ? 2'h3 : 2'h0;
        phy_d_in <= 8'h00;
        if (ack_on && $fell(phy_ctl_oe)) begin
            phy_ctl_in <= 2'h2;
            phy_d_in <= 8'h01;
        end
    end
endmodule : alc_phy_model

// ==== testbench/testbench.sv ====
/*
 Directed tests through the host byte port and link events.
 Assumes core, FIFO, checker and PHY model compiled before it.
*/
`timescale 1ns/1ps
module testbench;
    logic ref_clk, arst_n, link_clk, hif_d_oe, phy_ctl_oe, phy_d_oe, phy_lreq;
    logic node_is_root, rx_done, ack_on;
    logic [7:0] hif_d_out, phy_d_in, phy_d_out, r;
    logic [1:0] phy_ctl_in, phy_ctl_out;
    alc_pkg::alc_hif_t hif_in;
    alc_pkg::alc_rx_t rx_info;
    alc_pkg::alc_ev_t bus_ev;
    int fails, cmp_count;
    alc_core dut (.*);
    alc_phy_model phy (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One strobe per byte, held long enough for the synchroniser
    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        hif_in = {1'b0, !w, w, a, d};
        repeat (5) @(negedge ref_clk);
        r = hif_d_out;
        hif_in = {3'h7, a, d};
        repeat (4) @(negedge ref_clk);
    endtask : acc
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(r, exp);
    endtask : rd
    task automatic wq(input logic [8:0] a, input logic [31:0] q);
        for (int i = 0; i < 4; i++) acc(1'b1, a | 9'(i), q[8*i+:8]);
    endtask : wq
    // Received packet end, then the first byte the core drives back
    task automatic rxp(input logic busy, input logic [15:0] act, input logic [7:0] exp);
        @(negedge link_clk);
        rx_info = {1'b1, busy, 16'h0004, act};
        rx_done = 1'b1;
        @(negedge link_clk);
        rx_done = 1'b0;
        for (int i = 0; i < 20 && !phy_ctl_oe; i++) @(negedge link_clk);
        chk(phy_d_out, exp);
    endtask : rxp
    task automatic evp(input logic [2:0] e);
        @(negedge link_clk);
        bus_ev = e;
        @(negedge link_clk);
        bus_ev = 3'h0;
    endtask : evp
    // Hang guard
    initial begin
        #3_000_000;
        fails++;
        end_of_test();
    end
    initial begin
        {arst_n, rx_done, node_is_root, ack_on, rx_info, bus_ev} = '0;
        hif_in = {3'h7, 9'h000, 8'h00};
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        rd(9'h084, 8'h55);
        rd(9'h007, 8'h00);
        // No acks: each request waits out its timeout, so the FIFO fills
        for (int i = 0; i < 24; i++) wq(9'h0C0, 32'(i));
        rd(9'h084, 8'h59);
        for (int i = 0; i < 200 && r !== 8'h55; i++) acc(1'b0, 9'h084, 8'h00);
        chk(r, 8'h55);
        repeat (800) @(negedge ref_clk);
        rd(9'h0C8, 8'h10);
        rd(9'h0A0, 8'h03);
        acc(1'b1, 9'h0A0, 8'h07);
        rd(9'h0A0, 8'h00);
        ack_on = 1'b1;
        wq(9'h0C4, 32'h0000_0000);
        rd(9'h0A0, 8'h04);
        wq(9'h0C0, 32'h0000_0000);
        repeat (100) @(negedge ref_clk);
        rd(9'h0C8, 8'h01);
        rd(9'h0A0, 8'h07);
        $display("host transfer tests done");
        rxp(1'b0, 16'h0008, 8'h0d);
        rxp(1'b1, 16'h0004, 8'h05);
        repeat (5) evp(3'h1);
        rxp(1'b1, 16'h0004, 8'h06);
        acc(1'b1, 9'h007, 8'h18);
        rd(9'h007, 8'h18);
        rxp(1'b1, 16'h0004, 8'h04);
        $display("acknowledge tests done");
        acc(1'b1, 9'h004, 8'h01);
        node_is_root = 1'b1;
        for (int k = 0; k < 2; k++) begin
            evp(3'h4);
            evp(3'h2);
            for (int i = 0; i < 40 && !phy_lreq; i++) @(negedge link_clk);
            chk({7'h00, phy_lreq}, 8'h01);
        end
        $display("isochronous tests done");
        end_of_test();
    end
endmodule : testbench
